// ### cts_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cts_host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i,
  // Event line
  input wire logic flag_i
);
  int toggles = 0;
  int pulse_len = 0;
  int run_len = 0;
  logic flag_q = 1'b1;

  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
    // Hand back on a rising edge so callers drive there
    @(posedge clk_i);
  endtask

  // Width of the last level run is the pulse width after its trailing edge
  always @(posedge clk_i) begin
    flag_q <= flag_i;
    if (flag_i !== flag_q) begin
      toggles <= toggles + 1;
      pulse_len <= run_len;
      run_len <= 1;
    end else begin
      run_len <= run_len + 1;
    end
  end
endmodule // cts_host_model
`default_nettype wire

// ### cts_irq_bit.sv
`timescale 1ns/1ps
`default_nettype none
module cts_irq_bit
  import cts_pkg::*;
#(
  parameter logic [1:0] EDGE_SEL = 2'h1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Event level and read clear
  input wire logic level_i,
  input wire logic clr_i,
  // Sticky flag
  output logic flag_o
);
  logic prev_reg;
  logic flag_reg;
  wire logic rise = level_i & ~prev_reg;
  wire logic fall = ~level_i & prev_reg;
  wire logic hit = (EDGE_SEL[0] & rise) | (EDGE_SEL[1] & fall);
  // Set wins over a clear in the same cycle
  wire logic flag_next = hit | (flag_reg & ~clr_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      prev_reg <= level_i;
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule // cts_irq_bit
`default_nettype wire

// ### cts_pkg.sv
package cts_pkg;
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHARGE_CURRENT_FIELD = 8'h01;
  localparam logic [7:0] ADDR_VCHG = 8'h02;
  localparam logic [7:0] ADDR_NTC1 = 8'h03;
  localparam logic [7:0] ADDR_NTC2 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] ADDR_STAT_INT = 8'h06;
  localparam logic [7:0] ADDR_CHARGE_FAULT_IRQ_A = 8'h07;
  localparam logic [7:0] ADDR_CHARGE_FAULT_IRQ_B = 8'h08;
  localparam logic [7:0] ADDR_BOOST_FAULT_IRQ = 8'h09;
  localparam logic [7:0] ADDR_STATUS_IRQ_MASK = 8'h0A;
  localparam logic [7:0] ADDR_CHARGE_FAULT_MASK_A = 8'h0B;
  localparam logic [7:0] ADDR_CHARGE_FAULT_MASK_B = 8'h0C;
  localparam logic [7:0] ADDR_BOOST_FAULT_MASK = 8'h0D;
  localparam logic [7:0] ADDR_INPUT_VOLTAGE_SENSE = 8'h0E;
  localparam logic [7:0] ADDR_BATTERY_VOLTAGE_SENSE = 8'h0F;
  localparam logic [7:0] ADDR_TEMPERATURE_SENSE = 8'h10;
  // Control register fields
  localparam int CTRL_CHARGE_ENABLE_BIT = 0;
  localparam int CTRL_FOLD_OPT = 1;
  localparam int CTRL_EXT_OPT = 2;
  localparam int CTRL_THERMISTOR_PRESENCE_ENABLE = 3;
  localparam int CTRL_INT_MASK = 4;
  localparam int CTRL_TRANS_EN = 5;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h29;
  localparam logic [3:0] CHARGE_CURRENT_FIELD_RST = 4'h4;
  localparam logic [3:0] VCHG_RST = 4'h8;
  localparam logic [7:0] NTC1_RST = 8'h42;
  localparam logic [7:0] NTC2_RST = 8'h1B;
  localparam logic [7:0] MSK_RST = 8'h00;
  // Charge current code: 100 mA per step, code 0 is the 400 mA floor
  localparam logic [3:0] FOLD_STEP = 4'h2;
  localparam logic [3:0] CHARGE_CURRENT_FIELD_MIN = 4'h0;
  localparam logic [1:0] FOLD_NONE = 2'h0;
  localparam logic [1:0] FOLD_M1 = 2'h1;
  localparam logic [1:0] FOLD_M2 = 2'h2;
  // Event pulse width in clock cycles
  localparam int unsigned EVENT_PULSE_CYC = 16;
  localparam int PULSE_CNT_W = 16;
  // Interrupt edge selection, two bits per interrupt bit
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [63:0] IRQ_EDGE_MAP = 64'h5555_5555_5595_FF55;

  typedef enum logic [3:0] {
    ST_OFF, ST_CONFIG, ST_WAIT, ST_WEAK_WAIT, ST_WEAK_SAFE, ST_WEAK_CHARGE,
    ST_SAFE, ST_FULL, ST_CV, ST_EOC, ST_FAULT, ST_BOOST
  } cts_state_t;

  typedef enum logic [1:0] {RM_IDLE, RM_HOLD} cts_rm_t;

  typedef struct packed {
    logic die_warn;
    logic die_m1;
    logic die_m2;
    logic die_sd;
    logic vin_uv_ok;
    logic vin_ov;
    logic vbat_at_vchg;
    logic vbat_low;
    logic ntc_cold;
    logic ntc_chilly;
    logic ntc_warm;
    logic ntc_hot;
    logic ntc_rmv;
    logic ntc_dis;
  } cts_cmp_t;
endpackage

// ### cts_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module cts_pulse_gen
  import cts_pkg::*;
#(
  parameter int unsigned WIDTH_CYC = EVENT_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Trigger and pulse window
  input wire logic start_i,
  output logic busy_o
);
  logic [PULSE_CNT_W-1:0] cnt_reg;
  logic busy_reg;
  wire logic last = (cnt_reg == '0);

  // A start during a running pulse is absorbed, not stretched
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (start_i && !busy_reg) begin
      cnt_reg <= PULSE_CNT_W'(WIDTH_CYC - 1);
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      cnt_reg <= last ? cnt_reg : cnt_reg - 1'b1;
      busy_reg <= ~last;
    end
  end

  assign busy_o = busy_reg;
endmodule // cts_pulse_gen
`default_nettype wire

// ### cts_supervisor.sv
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module cts_supervisor
  import cts_pkg::*;
#(
  parameter int unsigned PULSE_CYC = EVENT_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Comparators, charge state, board straps
  input wire cts_cmp_t cmp_i,
  input wire logic [3:0] chg_state_i,
  input wire logic batfet_present_i,
  input wire logic [7:0] bst_fault_i,
  // Charger controls
  output logic chg_halt_o,
  output logic [3:0] chg_current_o,
  output logic [3:0] chg_voltage_o,
  output logic [7:0] ntc_levels_o,
  output logic conv_en_o,
  output logic trans_en_o,
  output logic [3:0] state_req_o,
  output logic state_req_vld_o,
  output logic flag_o
);
  logic [7:0] ctrl_reg;
  logic [3:0] charge_current_field_reg;
  logic [3:0] vchg_reg;
  logic [7:0] ntc1_reg;
  logic [7:0] ntc2_reg;
  logic [31:0] msk_reg;
  logic [3:0] prev_state_reg;
  logic [1:0] fold_lvl_reg;
  logic [1:0] fold_lvl_next;
  logic rmv_prev_reg;
  cts_rm_t rm_reg;
  cts_rm_t rm_next;
  logic pend_any_reg;
  logic [7:0] rdata_reg;
  logic halt_reg;
  logic [3:0] cur_reg;
  logic [3:0] volt_reg;
  logic conv_reg;
  logic trans_reg;
  logic [3:0] req_reg;
  logic req_vld_reg;
  logic flag_reg;
  logic [31:0] irq_flag;
  logic pulse_busy;

  // Register decode
  wire logic hit_ctrl = (addr_i == ADDR_CTRL);
  wire logic hit_charge_current_field = (addr_i == ADDR_CHARGE_CURRENT_FIELD);
  wire logic hit_vchg = (addr_i == ADDR_VCHG);
  wire logic hit_ntc1 = (addr_i == ADDR_NTC1);
  wire logic hit_ntc2 = (addr_i == ADDR_NTC2);
  wire logic [3:0] hit_int = {addr_i == ADDR_BOOST_FAULT_IRQ, addr_i == ADDR_CHARGE_FAULT_IRQ_B,
                              addr_i == ADDR_CHARGE_FAULT_IRQ_A, addr_i == ADDR_STAT_INT};
  wire logic [3:0] hit_msk = {addr_i == ADDR_BOOST_FAULT_MASK, addr_i == ADDR_CHARGE_FAULT_MASK_B,
                              addr_i == ADDR_CHARGE_FAULT_MASK_A, addr_i == ADDR_STATUS_IRQ_MASK};
  wire logic [3:0] rd_clr = {4{rd_i}} & hit_int;

  // Control fields
  wire logic charge_enable_bit = ctrl_reg[CTRL_CHARGE_ENABLE_BIT];
  wire logic fold_en = ctrl_reg[CTRL_FOLD_OPT];
  wire logic ext_en = ctrl_reg[CTRL_EXT_OPT];
  wire logic ntc_chk_en = ctrl_reg[CTRL_THERMISTOR_PRESENCE_ENABLE];
  wire logic glob_msk = ctrl_reg[CTRL_INT_MASK];
  wire logic trans_sw = ctrl_reg[CTRL_TRANS_EN];

  // Charge state classes
  wire cts_state_t st = cts_state_t'(chg_state_i);
  wire logic st_charging = (st == ST_WEAK_SAFE) || (st == ST_WEAK_CHARGE) ||
                           (st == ST_SAFE) || (st == ST_FULL) || (st == ST_CV);
  wire logic st_flag_low = st_charging || (st == ST_WAIT);

  // Battery temperature windows
  wire logic ntc_mon = ~cmp_i.ntc_dis;
  wire logic rmv_eff = cmp_i.ntc_rmv & ntc_chk_en & ntc_mon;
  wire logic temp_out = ntc_mon & (ext_en ? (cmp_i.ntc_cold | cmp_i.ntc_hot)
                                          : (cmp_i.ntc_cold | cmp_i.ntc_warm));
  wire logic temp_band = ntc_mon & ext_en &
                         ((cmp_i.ntc_warm & ~cmp_i.ntc_hot) |
                          (cmp_i.ntc_chilly & ~cmp_i.ntc_cold));
  wire logic halt_now = ~charge_enable_bit | cmp_i.die_sd | rmv_eff | temp_out;

  // Die foldback level; idle when the option is off
  always_comb begin
    fold_lvl_next = fold_lvl_reg;
    if (!fold_en || !cmp_i.die_warn) begin
      fold_lvl_next = FOLD_NONE;
    end else if (cmp_i.die_m2) begin
      fold_lvl_next = FOLD_M2;
    end else if (cmp_i.die_m1 && fold_lvl_reg == FOLD_NONE) begin
      fold_lvl_next = FOLD_M1;
    end
  end

  wire logic [3:0] charge_current_field_m1 = (charge_current_field_reg > FOLD_STEP) ? charge_current_field_reg - FOLD_STEP : CHARGE_CURRENT_FIELD_MIN;
  wire logic [3:0] charge_current_field_fold = (fold_lvl_reg == FOLD_M2) ? CHARGE_CURRENT_FIELD_MIN :
                               (fold_lvl_reg == FOLD_M1) ? charge_current_field_m1 : charge_current_field_reg;
  wire logic [3:0] red_cur = ntc1_reg[3:0];
  wire logic [3:0] cur_now = (temp_band && red_cur < charge_current_field_fold) ? red_cur : charge_current_field_fold;
  wire logic [3:0] volt_now = temp_band ? ntc1_reg[7:4] : vchg_reg;

  // Removal response and end of charge without thermistor
  wire logic rmv_fire = rmv_eff & ~rmv_prev_reg;
  wire logic eoc_now = cmp_i.ntc_dis & cmp_i.vbat_at_vchg & st_charging;
  logic [3:0] req_now;
  logic req_vld_now;

  always_comb begin
    rm_next = rm_reg;
    req_now = 4'h0;
    req_vld_now = 1'b0;
    case (rm_reg)
      RM_IDLE: begin
        if (rmv_fire) begin
          req_now = ST_FAULT;
          req_vld_now = 1'b1;
          rm_next = RM_HOLD;
        end else if (eoc_now) begin
          req_now = ST_EOC;
          req_vld_now = 1'b1;
        end
      end
      RM_HOLD: begin
        if (st == ST_FAULT) begin
          rm_next = RM_IDLE;
          if (batfet_present_i) begin
            req_now = ST_WEAK_WAIT;
            req_vld_now = 1'b1;
          end
        end
      end
      default: rm_next = RM_IDLE;
    endcase
  end

  // Interrupt sources: status, charge fault A, charge fault B, boost
  wire logic st_change = (chg_state_i != prev_state_reg);
  wire logic [7:0] stat_lev = {cmp_i.ntc_hot & ntc_mon, cmp_i.ntc_warm & ntc_mon,
                               cmp_i.ntc_chilly & ntc_mon, cmp_i.ntc_cold & ntc_mon,
                               cmp_i.die_m2 & fold_en, cmp_i.die_m1 & fold_en,
                               cmp_i.die_warn & st_charging, st_change};
  wire logic [7:0] ch1_lev = {4'h0, cmp_i.vin_uv_ok, cmp_i.vin_ov, cmp_i.die_sd, rmv_eff};
  wire logic [7:0] ch2_lev = {7'h00, (st == ST_EOC) & cmp_i.vbat_low};
  wire logic [31:0] irq_lev = {bst_fault_i, ch2_lev, ch1_lev, stat_lev};

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_irq
      cts_irq_bit #(
        .EDGE_SEL(IRQ_EDGE_MAP[2*gi +: 2])
      ) u_bit (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .level_i(irq_lev[gi]),
        .clr_i(rd_clr[gi/8]),
        .flag_o(irq_flag[gi])
      );
    end
  endgenerate

  // Summaries and FLAG pulse request
  wire logic stat_sum = |irq_flag[7:0];
  wire logic fault_sum = |irq_flag[31:8];
  wire logic pend_now = (|(irq_flag & ~msk_reg)) & ~glob_msk;
  wire logic pulse_start = pend_now & ~pend_any_reg;

  cts_pulse_gen #(
    .WIDTH_CYC(PULSE_CYC)
  ) u_pulse (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(pulse_start),
    .busy_o(pulse_busy)
  );

  // Read mux; sense values are live, not latched
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (1'b1)
      hit_ctrl: rd_mux = ctrl_reg;
      hit_charge_current_field: rd_mux = {4'h0, charge_current_field_reg};
      hit_vchg: rd_mux = {4'h0, vchg_reg};
      hit_ntc1: rd_mux = ntc1_reg;
      hit_ntc2: rd_mux = ntc2_reg;
      (addr_i == ADDR_STATUS): rd_mux = {fault_sum, stat_sum, batfet_present_i,
                                         ~cmp_i.ntc_dis, chg_state_i};
      hit_int[0]: rd_mux = irq_flag[7:0];
      hit_int[1]: rd_mux = irq_flag[15:8];
      hit_int[2]: rd_mux = irq_flag[23:16];
      hit_int[3]: rd_mux = irq_flag[31:24];
      hit_msk[0]: rd_mux = msk_reg[7:0];
      hit_msk[1]: rd_mux = msk_reg[15:8];
      hit_msk[2]: rd_mux = msk_reg[23:16];
      hit_msk[3]: rd_mux = msk_reg[31:24];
      (addr_i == ADDR_INPUT_VOLTAGE_SENSE): rd_mux = {6'h00, cmp_i.vin_ov, cmp_i.vin_uv_ok};
      (addr_i == ADDR_BATTERY_VOLTAGE_SENSE): rd_mux = {4'h0, cmp_i.ntc_dis, cmp_i.ntc_rmv,
                                           cmp_i.vbat_low, cmp_i.vbat_at_vchg};
      (addr_i == ADDR_TEMPERATURE_SENSE): rd_mux = {cmp_i.ntc_hot, cmp_i.ntc_warm,
                                           cmp_i.ntc_chilly, cmp_i.ntc_cold,
                                           cmp_i.die_sd, cmp_i.die_m2,
                                           cmp_i.die_m1, cmp_i.die_warn};
      default: rd_mux = 8'h00;
    endcase
  end

  // Software registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RST;
      charge_current_field_reg <= CHARGE_CURRENT_FIELD_RST;
      vchg_reg <= VCHG_RST;
      ntc1_reg <= NTC1_RST;
      ntc2_reg <= NTC2_RST;
      msk_reg <= {4{MSK_RST}};
    end else if (wr_i) begin
      if (hit_ctrl) ctrl_reg <= wdata_i;
      if (hit_charge_current_field) charge_current_field_reg <= wdata_i[3:0];
      if (hit_vchg) vchg_reg <= wdata_i[3:0];
      if (hit_ntc1) ntc1_reg <= wdata_i;
      if (hit_ntc2) ntc2_reg <= wdata_i;
      if (hit_msk[0]) msk_reg[7:0] <= wdata_i;
      if (hit_msk[1]) msk_reg[15:8] <= wdata_i;
      if (hit_msk[2]) msk_reg[23:16] <= wdata_i;
      if (hit_msk[3]) msk_reg[31:24] <= wdata_i;
    end
  end

  // Internal state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_state_reg <= 4'h0;
      fold_lvl_reg <= FOLD_NONE;
      rmv_prev_reg <= 1'b0;
      rm_reg <= RM_IDLE;
      pend_any_reg <= 1'b0;
    end else begin
      prev_state_reg <= chg_state_i;
      fold_lvl_reg <= fold_lvl_next;
      rmv_prev_reg <= rmv_eff;
      rm_reg <= rm_next;
      pend_any_reg <= pend_now;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
      halt_reg <= 1'b1;
      cur_reg <= CHARGE_CURRENT_FIELD_MIN;
      volt_reg <= VCHG_RST;
      conv_reg <= 1'b0;
      trans_reg <= 1'b0;
      req_reg <= 4'h0;
      req_vld_reg <= 1'b0;
      flag_reg <= 1'b1;
    end else begin
      rdata_reg <= rd_i ? rd_mux : 8'h00;
      halt_reg <= halt_now;
      cur_reg <= cur_now;
      volt_reg <= volt_now;
      conv_reg <= (st != ST_EOC) && (st != ST_FAULT) && (st != ST_OFF);
      trans_reg <= cmp_i.vin_uv_ok & ~cmp_i.vin_ov & trans_sw;
      req_reg <= req_now;
      req_vld_reg <= req_vld_now;
      flag_reg <= ~st_flag_low ^ pulse_busy;
    end
  end

  assign rdata_o = rdata_reg;
  assign chg_halt_o = halt_reg;
  assign chg_current_o = cur_reg;
  assign chg_voltage_o = volt_reg;
  assign ntc_levels_o = ntc2_reg;
  assign conv_en_o = conv_reg;
  assign trans_en_o = trans_reg;
  assign state_req_o = req_reg;
  assign state_req_vld_o = req_vld_reg;
  assign flag_o = flag_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_pulse_start;
    !pulse_busy ##1 pulse_busy;
  endsequence

  fold_m2_a: assert property (fold_en && cmp_i.die_warn && cmp_i.die_m2
    |=> ##1 chg_current_o == CHARGE_CURRENT_FIELD_MIN) else $error("foldback floor not applied");
  fold_off_a: assert property (!fold_en ##1 (!fold_en && !temp_band)
    |=> chg_current_o == $past(charge_current_field_reg)) else $error("current changed with foldback off");
  fold_restore_a: assert property (!cmp_i.die_warn |=> fold_lvl_reg == FOLD_NONE)
    else $error("foldback not released");
  halt_sd_a: assert property (cmp_i.die_sd |=> chg_halt_o)
    else $error("shutdown did not halt charge");
  halt_window_a: assert property (ntc_mon && !ext_en && cmp_i.ntc_warm |=> chg_halt_o)
    else $error("warm battery not halted");
  trans_gate_a: assert property (!cmp_i.vin_uv_ok || !trans_sw |=> !trans_en_o)
    else $error("transceiver supply on outside window");
  pulse_width_a: assert property (s_pulse_start |-> pulse_busy [*8])
    else $error("event pulse too short");
  pulse_once_a: assert property (pend_any_reg && pend_now && !pulse_busy
    |=> !pulse_busy) else $error("second pulse while interrupts pend");
  flag_rest_a: assert property (!pulse_busy && st_flag_low |=> !flag_o)
    else $error("flag not low while charging");
  rmv_fault_a: assert property (rmv_fire && rm_reg == RM_IDLE
    |=> state_req_vld_o && state_req_o == ST_FAULT) else $error("removal fault missing");
endmodule // cts_supervisor
`default_nettype wire

// ### cts_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cts_supervisor_tb;
  import cts_pkg::*;
  localparam int PW = 10;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr, wdata, rdata, ev, lvls;
  logic wr, rd, halt, conv_en, trans_en, req_vld, flag;
  logic [3:0] cur, volt, req;
  logic [3:0] last_req = 4'h0;
  cts_cmp_t cmp = '0;
  cts_state_t state = ST_OFF;
  logic batfet = 1'b0;
  logic [7:0] bst = 8'h00;
  logic [7:0] ctrl = CTRL_RST;
  logic [3:0] charge_current_field = CHARGE_CURRENT_FIELD_RST;
  logic [3:0] bands [5] = '{4'h4, 4'hC, 4'h2, 4'h3, 4'h0};
  int fail_count = 0;
  int n_compared = 0;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (req_vld) last_req <= req;

  cts_supervisor #(.PULSE_CYC(PW)) cts_supervisor_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .cmp_i(cmp), .chg_state_i(state),
    .batfet_present_i(batfet), .bst_fault_i(bst), .chg_halt_o(halt),
    .chg_current_o(cur), .chg_voltage_o(volt), .ntc_levels_o(lvls), .conv_en_o(conv_en),
    .trans_en_o(trans_en), .state_req_o(req), .state_req_vld_o(req_vld), .flag_o(flag));

  cts_host_model cts_host_model_i (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata), .flag_i(flag));

  // Reference: {halt, transceiver, voltage, current} from settings and comparators
  function automatic logic [9:0] model_out();
    int c;
    int fold;
    logic ext, band, stop;
    c = charge_current_field;
    fold = !(ctrl[1] && cmp.die_warn) ? 0 : cmp.die_m2 ? 2 : cmp.die_m1 ? 1 : 0;
    if (fold == 1) c = (c > 2) ? c - 2 : 0;
    if (fold == 2) c = 0;
    ext = ctrl[2];
    band = ext && !cmp.ntc_dis &&
      ((cmp.ntc_warm && !cmp.ntc_hot) || (cmp.ntc_chilly && !cmp.ntc_cold));
    if (band && NTC1_RST[3:0] < c) c = NTC1_RST[3:0];
    stop = !ctrl[0] || cmp.die_sd || (cmp.ntc_rmv && ctrl[3] && !cmp.ntc_dis) ||
      (!cmp.ntc_dis && (cmp.ntc_cold || (ext ? cmp.ntc_hot : cmp.ntc_warm)));
    return {stop, cmp.vin_uv_ok && !cmp.vin_ov && ctrl[5],
      band ? NTC1_RST[7:4] : VCHG_RST, 4'(c)};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    cts_host_model_i.rd_reg(a, d);
    check({8'h00, d}, {8'h00, e});
  endtask

  task automatic clr(input logic [7:0] a);
    logic [7:0] d;
    cts_host_model_i.rd_reg(a, d);
  endtask

  task automatic set_ctrl(input logic [7:0] v);
    ctrl = v;
    cts_host_model_i.wr_reg(ADDR_CTRL, v);
  endtask

  // Foldback needs two cycles, so four is a safe settle
  task automatic chk_out();
    tick(4);
    check({6'h00, halt, trans_en, volt, cur}, {6'h00, model_out()});
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    tick(20000);
    fail_count++;
    complete_run();
  end

  initial begin
    void'($urandom(32'hc67baa20));
    tick(12);
    check({flag, halt, trans_en, conv_en, req_vld, 3'h0, rdata}, {5'b11000, 11'h000});
    rst_n_i <= 1'b1;
    chk_rd(ADDR_CTRL, CTRL_RST);
    chk_rd(ADDR_CHARGE_CURRENT_FIELD, {4'h0, CHARGE_CURRENT_FIELD_RST});
    chk_rd(ADDR_VCHG, {4'h0, VCHG_RST});
    chk_rd(ADDR_NTC1, NTC1_RST);
    chk_rd(ADDR_NTC2, NTC2_RST);
    ev = 8'($urandom());
    cts_host_model_i.wr_reg(ADDR_NTC2, ev);
    tick(1);
    check({8'h00, lvls}, {8'h00, ev});
    chk_rd(ADDR_CHARGE_FAULT_MASK_A, MSK_RST);
    chk_rd(8'h3F, 8'h00);
    state <= ST_FULL;
    cmp.vin_uv_ok <= 1'b1;
    chk_out();
    clr(ADDR_STAT_INT);
    cmp.die_warn <= 1'b1;
    tick(3);
    chk_rd(ADDR_STAT_INT, 8'h02);
    chk_rd(ADDR_STAT_INT, 8'h00);
    chk_rd(ADDR_TEMPERATURE_SENSE, 8'h01);
    cmp.die_warn <= 1'b0;
    charge_current_field = 4'($urandom_range(15, 3));
    cts_host_model_i.wr_reg(ADDR_CHARGE_CURRENT_FIELD, {4'h0, charge_current_field});
    for (int o = 0; o < 2; o++) begin
      set_ctrl(o ? CTRL_RST : (CTRL_RST | 8'h02));
      clr(ADDR_STAT_INT);
      for (int s = 0; s < 3; s++) begin
        cmp.die_warn <= 1'b1;
        cmp.die_m1 <= (s > 0);
        cmp.die_m2 <= (s > 1);
        chk_out();
      end
      chk_rd(ADDR_STAT_INT, o ? 8'h02 : 8'h0E);
      {cmp.die_warn, cmp.die_m1, cmp.die_m2} <= 3'b000;
      chk_out();
    end
    for (int x = 0; x < 2; x++) begin
      set_ctrl(CTRL_RST | (x ? 8'h04 : 8'h00));
      clr(ADDR_STAT_INT);
      foreach (bands[b]) begin
        {cmp.ntc_hot, cmp.ntc_warm, cmp.ntc_chilly, cmp.ntc_cold} <= bands[b];
        chk_out();
      end
      chk_rd(ADDR_STAT_INT, 8'hF0);
    end
    {cmp.ntc_dis, cmp.ntc_hot, cmp.ntc_warm} <= 3'b111;
    chk_out();
    {cmp.ntc_dis, cmp.ntc_hot, cmp.ntc_warm} <= 3'b000;
    for (int t = 0; t < 8; t++) begin
      set_ctrl(t[2] ? CTRL_RST : (CTRL_RST & 8'hDF));
      {cmp.vin_uv_ok, cmp.vin_ov} <= 2'(t);
      chk_out();
    end
    cmp.vin_ov <= 1'b0;
    clr(ADDR_CHARGE_FAULT_IRQ_A);
    cmp.die_sd <= 1'b1;
    chk_out();
    chk_rd(ADDR_CHARGE_FAULT_IRQ_A, 8'h02);
    cmp.die_sd <= 1'b0;
    cmp.ntc_rmv <= 1'b1;
    chk_out();
    check({12'h000, last_req}, {12'h000, 4'(ST_FAULT)});
    chk_rd(ADDR_CHARGE_FAULT_IRQ_A, 8'h01);
    batfet <= 1'b1;
    state <= ST_FAULT;
    tick(4);
    check({12'h000, last_req}, {12'h000, 4'(ST_WEAK_WAIT)});
    cmp.ntc_rmv <= 1'b0;
    state <= ST_EOC;
    clr(ADDR_CHARGE_FAULT_IRQ_B);
    cmp.vbat_low <= 1'b1;
    tick(3);
    chk_rd(ADDR_CHARGE_FAULT_IRQ_B, 8'h01);
    check({15'h0000, conv_en}, 16'h0000);
    state <= ST_FULL;
    {cmp.ntc_dis, cmp.vbat_at_vchg} <= 2'b11;
    tick(3);
    check({12'h000, last_req}, {12'h000, 4'(ST_EOC)});
    {cmp.ntc_dis, cmp.vbat_at_vchg} <= 2'b00;
    tick(3 * PW);
    for (int a = 6; a < 10; a++) clr(8'(a));
    tick(3 * PW);
    check({15'h0000, flag}, 16'h0000);
    ev = 8'(cts_host_model_i.toggles);
    bst[0] <= 1'b1;
    tick(PW + 6);
    check(16'(8'(cts_host_model_i.toggles) - ev), 16'h0002);
    check(16'(cts_host_model_i.pulse_len), 16'(PW));
    chk_rd(ADDR_STATUS, {4'hB, 4'(ST_FULL)});
    bst[1] <= 1'b1;
    tick(PW);
    check(16'(8'(cts_host_model_i.toggles) - ev), 16'h0002);
    chk_rd(ADDR_BOOST_FAULT_IRQ, 8'h03);
    cts_host_model_i.wr_reg(ADDR_BOOST_FAULT_MASK, 8'h04);
    bst[2] <= 1'b1;
    tick(PW);
    set_ctrl(CTRL_RST | 8'h10);
    clr(ADDR_BOOST_FAULT_IRQ);
    bst[3] <= 1'b1;
    tick(PW);
    check(16'(8'(cts_host_model_i.toggles) - ev), 16'h0002);
    set_ctrl(CTRL_RST);
    clr(ADDR_BOOST_FAULT_IRQ);
    state <= ST_FAULT;
    tick(3 * PW);
    check({15'h0000, flag}, 16'h0001);
    for (int r = 0; r < 4; r++) begin
      cmp <= cts_cmp_t'(14'($urandom()));
      tick(2);
      ev = {cmp.ntc_hot, cmp.ntc_warm, cmp.ntc_chilly, cmp.ntc_cold,
        cmp.die_sd, cmp.die_m2, cmp.die_m1, cmp.die_warn};
      chk_rd(ADDR_TEMPERATURE_SENSE, ev);
      chk_rd(ADDR_INPUT_VOLTAGE_SENSE, {6'h00, cmp.vin_ov, cmp.vin_uv_ok});
      ev = {4'h0, cmp.ntc_dis, cmp.ntc_rmv, cmp.vbat_low, cmp.vbat_at_vchg};
      chk_rd(ADDR_BATTERY_VOLTAGE_SENSE, ev);
    end
    complete_run();
  end
endmodule // cts_supervisor_tb
`default_nettype wire
